// >>> rtl/tag_command_core.sv
`include "tag_map.svh"
module tag_command_core #(
	parameter int unsigned WRESP_CYCLES = `WRESP_CYCLES,
	parameter int unsigned RESET_CYCLES = `RESET_CYCLES
) (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        srst,
	// powering field present
	input  wire logic        fieldOn,
	// demodulated command bits
	input  wire logic        rxBit,
	input  wire logic        rxValid,
	input  wire logic        rxEof,
	// response bits to the modulator
	output logic             txValid,
	input  wire logic        txReady,
	output logic             txBit,
	output logic             txManchester,
	output logic             txFast,
	// avalon-mm slave
	input  wire logic [3:0]  avAddress,
	input  wire logic        avRead,
	input  wire logic        avWrite,
	input  wire logic [31:0] avWriteData,
	input  wire logic [3:0]  avByteEnable,
	output logic [31:0]      avReadData,
	output logic             avWaitRequest,
	// current protocol state
	output tag_pkg::tag_state_t tagState
);
	import tag_pkg::*;
	localparam int WW = $clog2(WRESP_CYCLES + 1);
	localparam int RW = $clog2(RESET_CYCLES + 1);
	typedef struct packed {
		tag_state_t   state;
		resp_mode_t   mode;
		logic [5:0]   pageSel;
		tx_phase_t    phase;
		logic [WW-1:0] waitCnt;
		logic [RW-1:0] offCnt;
		logic [7:0]   bitIdx;
		logic [7:0]   endIdx;
		logic [2:0]   sofLeft;
		logic         crcOn;
		logic         manchester;
		logic         fast;
		logic [127:0] payload;
		logic         txBit;
		logic [7:0]   crc;
		logic [2:0]   crcIdx;
		logic         rdDone;
		logic [31:0]  rdData;
	} core_t;
	core_t st;
	core_t next_st;
	logic [31:0] pages [64];
	tag_core_if link ();

	frame_rx u_rx (
		.ref_clk (ref_clk),
		.srst    (srst),
		.rxBit   (rxBit),
		.rxValid (rxValid),
		.rxEof   (rxEof),
		.link    (link)
	);
	challenge_cipher u_cipher (
		.c (link)
	);

	// words travel low byte first, each byte msb first
	function automatic logic [31:0] airWord(input logic [`FRAME_MAX-1:0] f, input int base);
		logic [4:0] ii;
		airWord = '0;
		for (int i = 0; i < 32; i++) begin
			ii = 5'(i);
			airWord[{ii[4:3], ~ii[2:0]}] = f[base + i];
		end
	endfunction
	function automatic logic [7:0] fieldMsb(input logic [`FRAME_MAX-1:0] f, input int base,
		input int width);
		fieldMsb = '0;
		for (int i = 0; i < width; i++)
			fieldMsb = {fieldMsb[6:0], f[base + i]};
	endfunction
	function automatic logic bitAt(input logic [127:0] p, input logic [7:0] i);
		bitAt = p[{i[6:3], ~i[2:0]}];
	endfunction

	// command decode
	logic [7:0]  kField;
	logic [4:0]  kVal;
	logic [7:0]  code4;
	logic [7:0]  pIdx;
	logic [31:0] serialId;
	logic [31:0] cfg;
	logic [31:0] cfgReply;
	logic        authBit;
	logic        acMatch;
	logic        frameGood;
	logic        cmdAc;
	logic        cmdSelect;
	logic        cmdSilence;
	logic        cmdChal;
	logic        cmdRead;
	logic        cmdBlock;
	logic        accept;
	logic [2:0]  nWords;
	logic [127:0] blockData;
	assign kField = fieldMsb(link.frame, 0, 5);
	assign kVal = kField[4:0];
	assign code4 = fieldMsb(link.frame, 0, 4);
	assign pIdx = fieldMsb(link.frame, 4, 8);
	assign serialId = pages[`PAGE_SERIAL];
	assign cfg = pages[`PAGE_CFG];
	assign authBit = cfg[`CFG_AUTH_BIT];
	assign cfgReply = (authBit && cfg[`CFG_LOCK_BIT]) ? {8'hff, cfg[23:0]} : cfg;
	assign link.randomWord = airWord(link.frame, 0);
	assign link.secretWord = airWord(link.frame, 32);
	assign link.keyWord = pages[`PAGE_KEY];
	assign link.plainWord = {pages[`PAGE_PWD][15:0], cfg[31:16]};
	always_comb begin
		acMatch = 1'b1;
		for (int i = 0; i < 32; i++)
			if (5'(i) < kVal && link.frame[5 + i] != serialId[{i[4:3], ~i[2:0]}])
				acMatch = 1'b0;
	end
	// a reply in progress, bad crc or a wrong state drops the frame
	assign frameGood = link.done && link.crcOk && st.phase == TX_IDLE && fieldOn;
	assign cmdAc = frameGood && st.state == ST_INIT && kVal != 5'h00
		&& link.len == `LEN_AC_BASE + {2'h0, kVal} && acMatch;
	assign cmdSelect = frameGood && st.state == ST_INIT && link.len == `LEN_SELECT
		&& kVal == 5'h00 && airWord(link.frame, 5) == serialId;
	assign cmdSilence = frameGood && st.state == ST_INIT && link.len == `LEN_SILENCE
		&& kVal == 5'h00 && airWord(link.frame, 5) == serialId && !link.frame[37];
	assign cmdChal = frameGood && st.state == ST_AUTH && link.len == `LEN_CHALLENGE
		&& link.pass;
	assign cmdRead = frameGood && st.state == ST_SEL && link.len == `LEN_READ
		&& code4 == `CODE_READ_PAGE && pIdx[7:6] == 2'h0;
	assign cmdBlock = frameGood && st.state == ST_SEL && link.len == `LEN_READ
		&& code4 == `CODE_READ_BLOCK && pIdx[7:6] == 2'h0;
	assign accept = cmdAc || cmdSelect || cmdSilence || cmdChal || cmdRead || cmdBlock;
	assign nWords = {1'b0, ~pIdx[1:0]} + 3'h1;
	always_comb begin
		for (int w = 0; w < 4; w++)
			blockData[w * 32 +: 32] = pages[{pIdx[5:2], 2'(pIdx[1:0] + 2'(w))}];
	end

	// next state of the whole core
	always_comb begin
		next_st = st;
		next_st.rdDone = avRead && !st.rdDone;
		if (avRead && !st.rdDone) begin
			case (avAddress)
				`REG_MODE:      next_st.rdData = {30'h0, st.mode};
				`REG_STATUS:    next_st.rdData = {28'h0, st.phase != TX_IDLE, st.state};
				`REG_PAGE_SEL:  next_st.rdData = {26'h0, st.pageSel};
				`REG_PAGE_DATA: next_st.rdData = pages[st.pageSel];
				default:        next_st.rdData = 32'h0;
			endcase
		end
		// a mode write stands for the latest serial request
		if (avWrite && avByteEnable[0] && avAddress == `REG_MODE
			&& avWriteData[1:0] != 2'h3) begin
			next_st.mode = resp_mode_t'(avWriteData[1:0]);
			if (st.state == ST_READY)
				next_st.state = ST_INIT;
		end
		if (avWrite && avByteEnable[0] && avAddress == `REG_PAGE_SEL)
			next_st.pageSel = avWriteData[5:0];
		// command execution, reply parameters chosen by mode
		if (accept) begin
			next_st.phase = TX_WAIT;
			next_st.waitCnt = '0;
			next_st.bitIdx = 8'h00;
			next_st.endIdx = `WORD_BITS;
			next_st.crcOn = st.mode != MODE_STD;
			next_st.manchester = 1'b1;
			next_st.fast = st.mode == MODE_FADV;
			next_st.crc = `CRC_PRESET;
			next_st.sofLeft = (st.mode == MODE_STD) ? `SOF_STD : `SOF_MC_ADV;
			next_st.payload = {96'h0, cfgReply};
			if (cmdAc) begin
				next_st.payload = {96'h0, serialId};
				next_st.bitIdx = {3'h0, kVal};
				next_st.crcOn = 1'b0;
				next_st.manchester = 1'b0;
				next_st.sofLeft = (st.mode == MODE_STD) ? `SOF_STD : `SOF_AC_ADV;
				next_st.state = ST_INIT;
			end else if (cmdSelect) begin
				next_st.state = authBit ? ST_AUTH : ST_SEL;
			end else if (cmdSilence) begin
				next_st.payload = {120'h0, `ACK_PATTERN, 6'h00};
				next_st.endIdx = `ACK_BITS;
				next_st.crcOn = 1'b0;
				next_st.state = ST_QUIET;
			end else if (cmdChal) begin
				next_st.payload = {96'h0, link.response};
				next_st.state = ST_SEL;
			end else if (cmdRead) begin
				next_st.payload = {96'h0, pages[pIdx[5:0]]};
			end else begin
				next_st.payload = blockData;
				next_st.endIdx = {nWords, 5'h00};
			end
		end
		// reply serializer; the modulator paces bits with txReady
		case (st.phase)
			TX_WAIT: begin
				if (st.waitCnt == WW'(WRESP_CYCLES - 1)) begin
					next_st.phase = TX_SOF;
					next_st.txBit = 1'b1;
				end else begin
					next_st.waitCnt = st.waitCnt + WW'(1);
				end
			end
			TX_SOF: begin
				if (txReady) begin
					if (st.sofLeft == 3'h1) begin
						next_st.phase = TX_DATA;
						next_st.txBit = bitAt(st.payload, st.bitIdx);
					end else begin
						next_st.sofLeft = st.sofLeft - 3'h1;
					end
				end
			end
			TX_DATA: begin
				if (txReady) begin
					next_st.crc = crcStep(st.crc, st.txBit);
					next_st.bitIdx = st.bitIdx + 8'h01;
					if (st.bitIdx + 8'h01 == st.endIdx) begin
						next_st.phase = st.crcOn ? TX_CRC : TX_IDLE;
						next_st.crcIdx = 3'h7;
						next_st.txBit = next_st.crc[7];
					end else begin
						next_st.txBit = bitAt(st.payload, st.bitIdx + 8'h01);
					end
				end
			end
			TX_CRC: begin
				if (txReady) begin
					next_st.phase = (st.crcIdx == 3'h0) ? TX_IDLE : TX_CRC;
					next_st.crcIdx = st.crcIdx - 3'h1;
					next_st.txBit = st.crc[st.crcIdx - 3'h1];
				end
			end
			default: begin
			end
		endcase
		// short field gaps are ridden out; only a long loss powers down
		if (fieldOn) begin
			next_st.offCnt = '0;
			if (st.state == ST_OFF)
				next_st.state = ST_READY;
		end else if (st.offCnt == RW'(RESET_CYCLES - 1)) begin
			next_st.state = ST_OFF;
			next_st.phase = TX_IDLE;
		end else begin
			next_st.offCnt = st.offCnt + RW'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst)
			st <= '0;
		else
			st <= next_st;
	end

	// page store, loaded by software; no reset so it behaves like nvm
	always_ff @(posedge ref_clk) begin
		if (avWrite && avAddress == `REG_PAGE_DATA) begin
			for (int b = 0; b < 4; b++)
				if (avByteEnable[b])
					pages[st.pageSel][b * 8 +: 8] <= avWriteData[b * 8 +: 8];
		end
	end

	assign txValid = st.phase == TX_SOF || st.phase == TX_DATA || st.phase == TX_CRC;
	assign txBit = st.txBit;
	assign txManchester = st.manchester;
	assign txFast = st.fast;
	assign avReadData = st.rdData;
	assign avWaitRequest = avRead && !st.rdDone; // reads cost one wait state
	assign tagState = st.state;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_quiet_silent;
		st.state == ST_QUIET && st.phase == TX_IDLE |=> st.phase == TX_IDLE;
	endproperty
	a_quiet_silent: assert property (p_quiet_silent) else $error("quiet tag replied");
	property p_quiet_stays;
		st.state == ST_QUIET && fieldOn |=> st.state == ST_QUIET;
	endproperty
	a_quiet_stays: assert property (p_quiet_stays) else $error("quiet left in field");
	property p_wait_len;
		$past(st.phase) == TX_WAIT && st.phase == TX_SOF |-> $past(st.waitCnt) == WW'(WRESP_CYCLES - 1);
	endproperty
	a_wait_len: assert property (p_wait_len) else $error("reply wait length wrong");
	property p_plain_select;
		cmdSelect && !authBit |=> st.state == ST_SEL ##1 st.phase == TX_WAIT;
	endproperty
	a_plain_select: assert property (p_plain_select) else $error("plain select failed");
	property p_auth_select;
		cmdSelect && authBit |=> st.state == ST_AUTH;
	endproperty
	a_auth_select: assert property (p_auth_select) else $error("auth select failed");
	property p_auth_hold;
		st.state == ST_AUTH && fieldOn && !cmdChal |=> st.state == ST_AUTH;
	endproperty
	a_auth_hold: assert property (p_auth_hold) else $error("auth left early");
	property p_silence;
		cmdSilence |=> st.state == ST_QUIET && st.endIdx == `ACK_BITS;
	endproperty
	a_silence: assert property (p_silence) else $error("silence not quiet");
	property p_ac_init;
		st.state == ST_INIT && fieldOn && !cmdSelect && !cmdSilence |=> st.state == ST_INIT;
	endproperty
	a_ac_init: assert property (p_ac_init) else $error("init left badly");
	property p_no_cause;
		st.phase == TX_IDLE && !accept |=> st.phase == TX_IDLE;
	endproperty
	a_no_cause: assert property (p_no_cause) else $error("reply without command");
	property p_sof_len;
		$past(st.phase) == TX_WAIT && st.phase == TX_SOF |-> st.sofLeft ==
			(st.mode == MODE_STD ? `SOF_STD : (st.manchester ? `SOF_MC_ADV : `SOF_AC_ADV));
	endproperty
	a_sof_len: assert property (p_sof_len) else $error("start pattern length wrong");
endmodule

// >>> rtl/tag_map.svh
`ifndef TAG_MAP_SVH
`define TAG_MAP_SVH
// register byte offsets
`define REG_MODE        4'h0
`define REG_STATUS      4'h4
`define REG_PAGE_SEL    4'h8
`define REG_PAGE_DATA   4'hc
// timing: carrier period and system clock in ns
`define T0_NS           8000
`define CLK_NS          40
`define WRESP_T0        208
`define WRESP_CYCLES    ((`WRESP_T0 * `T0_NS) / `CLK_NS)
`define RESET_NS        4800000
`define RESET_CYCLES    ((`RESET_NS + `CLK_NS - 1) / `CLK_NS)
// frame lengths in bits, crc included, and read command codes
`define FRAME_MAX       72
`define LEN_AC_BASE     7'h0d
`define LEN_SELECT      7'h2d
`define LEN_SILENCE     7'h2e
`define LEN_READ        7'h14
`define LEN_CHALLENGE   7'h48
`define CODE_READ_PAGE  8'h0c
`define CODE_READ_BLOCK 8'h0d
// memory layout
`define PAGE_SERIAL     6'h00
`define PAGE_CFG        6'h01
`define PAGE_PWD        6'h02
`define PAGE_KEY        6'h03
`define CFG_AUTH_BIT    15
`define CFG_LOCK_BIT    14
`define ACK_PATTERN     2'h1
`define ACK_BITS        8'h02
`define WORD_BITS       8'h20
// crc8 and start patterns
`define CRC_POLY        8'h1d
`define CRC_PRESET      8'hff
`define SOF_STD         3'h1
`define SOF_AC_ADV      3'h3
`define SOF_MC_ADV      3'h6
`endif

// >>> rtl/tag_pkg.sv
`include "tag_map.svh"
package tag_pkg;
	typedef enum logic [2:0] {
		ST_OFF   = 3'h0,
		ST_READY = 3'h1,
		ST_INIT  = 3'h3,
		ST_AUTH  = 3'h2,
		ST_SEL   = 3'h6,
		ST_QUIET = 3'h7
	} tag_state_t;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_WAIT = 3'h1,
		TX_SOF  = 3'h3,
		TX_DATA = 3'h2,
		TX_CRC  = 3'h6
	} tx_phase_t;
	typedef enum logic [1:0] {
		MODE_STD  = 2'h0,
		MODE_ADV  = 2'h1,
		MODE_FADV = 2'h2
	} resp_mode_t;
	// one msb-first step of the crc8 shift register
	function automatic logic [7:0] crcStep(input logic [7:0] crc, input logic b);
		crcStep = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? `CRC_POLY : 8'h00);
	endfunction
endpackage

// >>> rtl/tag_core_if.sv
`include "tag_map.svh"
interface tag_core_if;
	logic [`FRAME_MAX-1:0] frame;
	logic [6:0]            len;
	logic                  done;
	logic                  crcOk;
	logic [31:0]           randomWord;
	logic [31:0]           secretWord;
	logic [31:0]           keyWord;
	logic [31:0]           plainWord;
	logic [31:0]           response;
	logic                  pass;
	modport rx (output frame, len, done, crcOk);
	modport cipher (input randomWord, secretWord, keyWord, plainWord, output response, pass);
	modport core (input frame, len, done, crcOk, response, pass,
		output randomWord, secretWord, keyWord, plainWord);
endinterface

// >>> rtl/frame_rx.sv
`include "tag_map.svh"
module frame_rx (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// demodulated command bits
	input wire logic rxBit,
	input wire logic rxValid,
	input wire logic rxEof,
	// collected frame
	tag_core_if.rx   link
);
	import tag_pkg::*;
	typedef struct packed {
		logic [`FRAME_MAX-1:0] frame;
		logic [6:0]            cnt;
		logic [6:0]            len;
		logic [7:0]            crc;
		logic                  done;
		logic                  ok;
	} rx_t;
	rx_t st;
	rx_t next_st;

	// bits land at their air position; crc runs over command and crc alike
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (rxValid) begin
			if (st.cnt < 7'(`FRAME_MAX))
				next_st.frame[st.cnt] = rxBit;
			if (st.cnt != 7'h7f)
				next_st.cnt = st.cnt + 7'h01; // saturate: overlong frames match nothing
			next_st.crc = crcStep(st.crc, rxBit);
		end
		if (rxEof) begin
			next_st.done = 1'b1;
			next_st.ok = (st.crc == 8'h00); // a good frame leaves a zero residue
			next_st.len = st.cnt;
			next_st.cnt = 7'h00;
			next_st.crc = `CRC_PRESET;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '0;
			st.crc <= `CRC_PRESET;
		end else begin
			st <= next_st;
		end
	end

	assign link.frame = st.frame;
	assign link.len = st.len;
	assign link.done = st.done;
	assign link.crcOk = st.ok;
endmodule

// >>> rtl/challenge_cipher.sv
module challenge_cipher (
	// challenge words in, verdict and response out
	tag_core_if.cipher c
);
	// stand-in for the undisclosed cipher; only the port contract is fixed
	assign c.pass = (c.secretWord == (c.randomWord ^ c.keyWord));
	assign c.response = c.plainWord ^ {c.randomWord[15:0], c.randomWord[31:16]};
endmodule

// >>> dv/reader_model.sv
module reader_model (
	// clock
	input  wire logic ref_clk,
	// command bits toward the tag
	output logic      rxBit,
	output logic      rxValid,
	output logic      rxEof,
	// reply bits from the tag
	input  wire logic txValid,
	output logic      txReady,
	input  wire logic txBit,
	input  wire logic txManchester,
	input  wire logic txFast
);
	timeunit 1ns;
	timeprecision 1ps;
	bit   gotQ[$];
	bit   slow;
	logic manSeen, fastSeen;

	// crc8 preset all ones, msb first
	function automatic logic [7:0] crc8(input bit q[$], input int from);
		logic [7:0] c;
		c = 8'hff;
		for (int i = from; i < q.size(); i++)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ q[i]) ? 8'h1d : 8'h00);
		return c;
	endfunction

	initial begin
		rxBit = 1'b0;
		rxValid = 1'b0;
		rxEof = 1'b0;
		txReady = 1'b1;
		slow = 1'b0;
	end

	// a slow modulator accepts only every other cycle
	always @(posedge ref_clk) begin
		if (txValid && txReady) begin
			gotQ.push_back(txBit);
			manSeen <= txManchester;
			fastSeen <= txFast;
		end
		txReady <= slow ? ~txReady : 1'b1;
	end

	// crc appended, then end of frame; released line shows the inverse bit
	task automatic send(input bit q[$], input bit badCrc);
		logic [7:0] c;
		c = crc8(q, 0) ^ {7'h0, badCrc};
		for (int i = 7; i >= 0; i--)
			q.push_back(c[i]);
		foreach (q[i]) begin
			@(posedge ref_clk);
			rxBit <= q[i];
			rxValid <= 1'b1;
			@(posedge ref_clk);
			rxValid <= 1'b0;
			rxBit <= ~q[i];
		end
		@(posedge ref_clk);
		rxEof <= 1'b1;
		@(posedge ref_clk);
		rxEof <= 1'b0;
	endtask

	// reply is over once no bit came for 60 cycles
	task automatic collect();
		int last, quiet;
		gotQ.delete();
		last = 0;
		quiet = 0;
		while (quiet < 60) begin
			@(negedge ref_clk);
			if (gotQ.size() == last) quiet++;
			else begin
				last = gotQ.size();
				quiet = 0;
			end
		end
	endtask
endmodule

// >>> dv/transponder_select_read_commands_test.sv
`include "tag_map.svh"
module transponder_select_read_commands_test;
	timeunit 1ns;
	timeprecision 1ps;
	import tag_pkg::*;
	localparam logic [31:0] SERIAL = 32'hb5a4c3d2;
	localparam logic [31:0] CFG = 32'h00001234;
	localparam logic [31:0] CFGA = 32'h7700c012;
	localparam logic [31:0] PWD = 32'h00005566;
	localparam logic [31:0] KEY = 32'h0f1e2d3c;
	localparam logic [31:0] RANDOM = 32'h9a3c5e71;
	// clock, reset, field, link
	logic        ref_clk, srst, fieldOn;
	logic        rxBit, rxValid, rxEof, txValid, txReady, txBit, txManchester, txFast;
	// register bus
	logic [3:0]  avAddress, avByteEnable;
	logic        avRead, avWrite, avWaitRequest;
	logic [31:0] avWriteData, avReadData, rdVal;
	tag_state_t  tagState;
	int          err_total, compares, sofLen;
	bit          cmdQ[$], expQ[$];

	tag_command_core #(.WRESP_CYCLES(20), .RESET_CYCLES(50)) DUT (
		.ref_clk(ref_clk), .srst(srst), .fieldOn(fieldOn),
		.rxBit(rxBit), .rxValid(rxValid), .rxEof(rxEof),
		.txValid(txValid), .txReady(txReady), .txBit(txBit),
		.txManchester(txManchester), .txFast(txFast),
		.avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
		.avWriteData(avWriteData), .avByteEnable(avByteEnable),
		.avReadData(avReadData), .avWaitRequest(avWaitRequest), .tagState(tagState));

	reader_model rdr (
		.ref_clk(ref_clk), .rxBit(rxBit), .rxValid(rxValid), .rxEof(rxEof),
		.txValid(txValid), .txReady(txReady), .txBit(txBit),
		.txManchester(txManchester), .txFast(txFast));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// request held until waitrequest is sampled low
	task automatic busWrite(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avAddress <= a;
		avWriteData <= d;
		avWrite <= 1'b1;
		do @(posedge ref_clk); while (avWaitRequest !== 1'b0);
		avWrite <= 1'b0;
	endtask

	task automatic busRead(input logic [3:0] a);
		@(posedge ref_clk);
		avAddress <= a;
		avRead <= 1'b1;
		do @(posedge ref_clk); while (avWaitRequest !== 1'b0);
		rdVal = avReadData;
		avRead <= 1'b0;
	endtask

	task automatic setPage(input logic [31:0] p, input logic [31:0] v);
		busWrite(`REG_PAGE_SEL, p);
		busWrite(`REG_PAGE_DATA, v);
	endtask

	task automatic chkState(input tag_state_t s);
		@(negedge ref_clk);
		chk("state", 32'(s), 32'(tagState));
	endtask

	task automatic doReset();
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		busWrite(`REG_MODE, 32'(MODE_STD));
	endtask

	// msb first into the command or the expected reply
	task automatic putBits(input logic [31:0] v, input int n, input bit toExp);
		for (int i = n - 1; i >= 0; i--)
			if (toExp) expQ.push_back(v[i]);
			else cmdQ.push_back(v[i]);
	endtask

	// air positions from..to-1: low byte first, each byte msb first
	task automatic putWord(input logic [31:0] w, input int from, input int to, input bit toExp);
		for (int n = from; n < to; n++)
			putBits(32'(w[8 * (n / 8) + 7 - n % 8]), 1, toExp);
	endtask

	task automatic expStart(input int sof);
		expQ.delete();
		sofLen = sof;
		putBits(32'h3f, sof, 1'b1);
	endtask

	task automatic expCrc();
		putBits(32'(rdr.crc8(expQ, sofLen)), 8, 1'b1);
	endtask

	task automatic run(input string what, input bit badCrc, input int readCode, input int page);
		int diffs;
		if (readCode != 0) begin
			putBits(32'(readCode), 4, 1'b0);
			putBits(32'(page), 8, 1'b0);
		end
		rdr.send(cmdQ, badCrc);
		cmdQ.delete();
		rdr.collect();
		diffs = 0;
		for (int i = 0; i < expQ.size() && i < rdr.gotQ.size(); i++)
			if (expQ[i] != rdr.gotQ[i]) diffs++;
		chk({what, " length"}, 32'(expQ.size()), 32'(rdr.gotQ.size()));
		chk({what, " bits"}, 32'h0, 32'(diffs));
		expQ.delete();
	endtask

	task automatic selFrame(input bit quiet);
		putBits(32'h0, 5, 1'b0);
		putWord(SERIAL, 0, 32, 1'b0);
		if (quiet) putBits(32'h0, 1, 1'b0);
	endtask

	initial begin
		repeat (30000) @(posedge ref_clk);
		err_total++;
		$display("[ERR] watchdog expired");
		report_and_stop();
	end

	initial begin
		srst = 1'b1;
		fieldOn = 1'b1;
		avAddress = 4'h0;
		avRead = 1'b0;
		avWrite = 1'b0;
		avWriteData = 32'h0;
		avByteEnable = 4'hf;
		repeat (5) @(posedge ref_clk);
		srst <= 1'b0;
		setPage(0, SERIAL);
		setPage(1, CFG);
		setPage(2, PWD);
		setPage(3, KEY);
		busRead(`REG_PAGE_DATA);
		chk("page data", KEY, rdVal);
		busRead(4'h2);
		chk("unmapped read", 32'h0, rdVal);
		busRead(`REG_STATUS);
		chk("status", 32'(ST_READY), rdVal & 32'h7);
		busWrite(`REG_MODE, 32'h3);
		busRead(`REG_MODE);
		chk("mode refused", 32'h0, rdVal & 32'h3);
		busWrite(`REG_MODE, 32'(MODE_STD));
		chkState(ST_INIT);
		$display("test registers done");
		// anticollision: matching prefix, mismatching prefix, advanced start
		putBits(32'h4, 5, 1'b0);
		putWord(SERIAL, 0, 4, 1'b0);
		expStart(1);
		putWord(SERIAL, 4, 32, 1'b1);
		run("ac std", 1'b0, 0, 0);
		chk("ac coding", 32'h0, 32'(rdr.manSeen));
		chkState(ST_INIT);
		putBits(32'h9, 5, 1'b0);
		putWord(SERIAL ^ 32'h8000, 0, 9, 1'b0);
		run("ac miss", 1'b0, 0, 0);
		chkState(ST_INIT);
		busWrite(`REG_MODE, 32'(MODE_ADV));
		putBits(32'h1, 5, 1'b0);
		putWord(SERIAL, 0, 1, 1'b0);
		expStart(3);
		putWord(SERIAL, 1, 32, 1'b1);
		run("ac adv", 1'b0, 0, 0);
		busWrite(`REG_MODE, 32'(MODE_STD));
		$display("test anticollision done");
		// refused commands, then plain selection and reads
		selFrame(1'b0);
		run("bad crc", 1'b1, 0, 0);
		run("read in init", 1'b0, 12, 2);
		chkState(ST_INIT);
		selFrame(1'b0);
		expStart(1);
		putWord(CFG, 0, 32, 1'b1);
		run("select", 1'b0, 0, 0);
		chk("select coding", 32'h1, 32'(rdr.manSeen));
		chkState(ST_SEL);
		expStart(1);
		putWord(PWD, 0, 32, 1'b1);
		run("page std", 1'b0, 12, 2);
		busWrite(`REG_MODE, 32'(MODE_ADV));
		rdr.slow = 1'b1;
		expStart(6);
		putWord(CFG, 0, 32, 1'b1);
		putWord(PWD, 0, 32, 1'b1);
		putWord(KEY, 0, 32, 1'b1);
		expCrc();
		run("block adv", 1'b0, 13, 1);
		rdr.slow = 1'b0;
		busWrite(`REG_MODE, 32'(MODE_FADV));
		expStart(6);
		putWord(SERIAL, 0, 32, 1'b1);
		expCrc();
		run("page fast", 1'b0, 12, 0);
		chk("fast rate", 32'h1, 32'(rdr.fastSeen));
		$display("test select and read done");
		// authenticated selection
		setPage(1, CFGA);
		doReset();
		selFrame(1'b0);
		expStart(1);
		putWord({8'hff, CFGA[23:0]}, 0, 32, 1'b1);
		run("auth select", 1'b0, 0, 0);
		chkState(ST_AUTH);
		putWord(RANDOM, 0, 32, 1'b0);
		putWord(RANDOM, 0, 32, 1'b0);
		run("bad challenge", 1'b0, 0, 0);
		chkState(ST_AUTH);
		putWord(RANDOM, 0, 32, 1'b0);
		putWord(RANDOM ^ KEY, 0, 32, 1'b0);
		expStart(1);
		putWord({PWD[15:0], CFGA[31:16]} ^ {RANDOM[15:0], RANDOM[31:16]}, 0, 32, 1'b1);
		run("challenge", 1'b0, 0, 0);
		chkState(ST_SEL);
		expStart(1);
		putWord(SERIAL, 0, 32, 1'b1);
		run("page after auth", 1'b0, 12, 0);
		$display("test authentication done");
		// silence, ignored commands, field loss
		doReset();
		selFrame(1'b1);
		expStart(1);
		putBits(32'h1, 2, 1'b1);
		run("silence", 1'b0, 0, 0);
		chkState(ST_QUIET);
		selFrame(1'b0);
		run("quiet select", 1'b0, 0, 0);
		chkState(ST_QUIET);
		@(posedge ref_clk);
		fieldOn <= 1'b0;
		repeat (40) @(posedge ref_clk);
		chkState(ST_QUIET);
		repeat (40) @(posedge ref_clk);
		chkState(ST_OFF);
		@(posedge ref_clk);
		fieldOn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chkState(ST_READY);
		$display("test quiet done");
		report_and_stop();
	end
endmodule
